/* File: verilog/spimsc_regs.vh */
// register offsets, field positions and reset values for the serial port core
`ifndef SPIMSC_REGS_VH
`define SPIMSC_REGS_VH
// byte addresses on the register bus
`define SPIMSC_CTL0_ADDR 12'h000
`define SPIMSC_CTL1_ADDR 12'h004
`define SPIMSC_STAT_ADDR 12'h008
`define SPIMSC_DATA_ADDR 12'h00c
`define SPIMSC_QCTL_ADDR 12'h010
// control_reg_0 fields
`define SPIMSC_C0_PHASE 0
`define SPIMSC_C0_POL 1
`define SPIMSC_C0_MASTER 2
`define SPIMSC_C0_PSC_LO 3
`define SPIMSC_C0_PSC_HI 5
`define SPIMSC_C0_EN 6
`define SPIMSC_C0_LSBF 7
`define SPIMSC_C0_SWLVL 8
`define SPIMSC_C0_SWEN 9
`define SPIMSC_C0_RO 10
`define SPIMSC_C0_F16 11
`define SPIMSC_C0_BDOE 14
`define SPIMSC_C0_BIDIRECTIONAL_ENABLE 15
// control_reg_1 fields
`define SPIMSC_C1_SELDRV 2
`define SPIMSC_C1_TI 4
// status fields
`define SPIMSC_ST_RNE 0
`define SPIMSC_ST_TBE 1
`define SPIMSC_ST_CFG 5
`define SPIMSC_ST_BUSY 7
// quad_control_reg fields
`define SPIMSC_Q_QEN 0
`define SPIMSC_Q_QRD 1
`define SPIMSC_Q_X23 2
// frame timing: index of the last edge of a frame, two edges per bit, two per four bits in quad
`define SPIMSC_LAST_EDGE_8 5'd15
`define SPIMSC_LAST_EDGE_16 5'd31
`define SPIMSC_LAST_EDGE_QUAD 5'd3
// reset values
`define SPIMSC_CTL0_RST 16'h0000
`define SPIMSC_CTL1_RST 8'h00
`define SPIMSC_QCTL_RST 3'h0
`endif

/* File: verilog/spimsc_core.v */
// serial peripheral port core, master or slave, with apb register access
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`include "spimsc_regs.vh"

module spimsc_core (
  // clock and reset
  input wire clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // serial clock pin
  input wire sck_i,
  output wire sck_o,
  output wire sck_oe,
  // select pin
  input wire sel_n_i,
  output wire sel_n_o,
  output wire sel_n_oe,
  // data lines 0..3 (mosi, miso, data_line_2, data_line_3)
  input wire [3:0] dl_i,
  output wire [3:0] dl_o,
  output wire [3:0] dl_oe
);

  // frame sequence, as seen from the state machine
  //   idle: clock at its idle level, select high, shifter waiting
  //   run:  one step per half period of the serial clock
  //         master: a step is a tick of the internal divider
  //         slave:  a step is a synchronised edge of the input clock
  //   last: one cycle to move the received word into the buffer
  // edges are counted from zero; in phase 0 the even edges sample and
  // the odd ones shift, in phase 1 the other way round
  // the very first edge never shifts: in phase 1 it only launches the
  // bit that the load already put on the line
  // the slave input clock passes two flops before an edge is seen,
  // so the external clock must be slow against the core clock;
  // a half period of four core cycles leaves a safe margin
  // the master samples through the same two-flop synchroniser, so a
  // prescaler of zero (one cycle per half period) is too fast for it
  // and the lowest usable setting is two
  // limitation: no overrun detection, a word not read in time is lost
  // and the receive flag simply stays set
  // trade-off: the frame end costs one idle cycle between back-to-back
  // frames, which keeps the restart decision in one place
  localparam ST_IDLE = 2'd0;
  localparam ST_RUN = 2'd1;
  localparam ST_LAST = 2'd2;

  reg [15:0] ctl0_ff;
  reg [7:0] ctl1_ff;
  reg [2:0] qctl_ff;
  reg [15:0] txbuf_ff;
  reg [15:0] rxbuf_ff;
  reg tbe_ff;
  reg rne_ff;
  reg cfg_ff;
  reg [1:0] st_ff;
  reg [15:0] sh_ff;
  reg [4:0] edge_ff;
  reg [7:0] div_ff;
  reg sck_ff;
  reg first_ff;
  reg [4:0] sync_ff [0:1];
  reg [4:0] smp_ff;
  wire [4:0] pins_s;

  // synchronise every pin input before use
  // two flops keep a metastable pin level away from the decode logic;
  // only the second stage is read, plus a third clock flop for edge detection
  always @(posedge clk) begin
    sync_ff[0] <= {sel_n_i, dl_i};
    sync_ff[1] <= sync_ff[0];
  end
  reg sck_s1_ff;
  reg sck_s2_ff;
  reg sck_prev_ff;
  always @(posedge clk) begin
    sck_s1_ff <= sck_i;
    sck_s2_ff <= sck_s1_ff;
    sck_prev_ff <= sck_s2_ff;
  end
  assign pins_s = sync_ff[1];

  // decoded configuration
  wire en = ctl0_ff[`SPIMSC_C0_EN];
  wire mst = ctl0_ff[`SPIMSC_C0_MASTER];
  wire ti = ctl1_ff[`SPIMSC_C1_TI];
  wire quad = qctl_ff[`SPIMSC_Q_QEN] & mst;
  wire qrd = qctl_ff[`SPIMSC_Q_QRD];
  wire bidirectional_enable = ctl0_ff[`SPIMSC_C0_BIDIRECTIONAL_ENABLE];
  wire bdoe = ctl0_ff[`SPIMSC_C0_BDOE];
  wire ro = ctl0_ff[`SPIMSC_C0_RO];
  wire swen = ctl0_ff[`SPIMSC_C0_SWEN];
  wire seldrv = ctl1_ff[`SPIMSC_C1_SELDRV];
  // ti mode fixes polarity and phase
  wire pol = ti ? 1'b0 : ctl0_ff[`SPIMSC_C0_POL];
  wire pha = ti ? 1'b1 : ctl0_ff[`SPIMSC_C0_PHASE];
  // ti and quad force msb first
  wire lsbf = ctl0_ff[`SPIMSC_C0_LSBF] & ~ti & ~quad;
  wire f16 = ctl0_ff[`SPIMSC_C0_F16] & ~quad;
  // select level from pin or software bit
  wire sel_lvl = swen ? ctl0_ff[`SPIMSC_C0_SWLVL] : pins_s[4];
  wire rx_only_m = mst & (ro | (bidirectional_enable & ~bdoe) | (quad & qrd));
  // edges per frame: two per bit, quad moves four bits per clock
  wire [4:0] last_edge = quad ? `SPIMSC_LAST_EDGE_QUAD :
                         (f16 ? `SPIMSC_LAST_EDGE_16 : `SPIMSC_LAST_EDGE_8);
  wire [7:0] half = (8'h01 << ctl0_ff[`SPIMSC_C0_PSC_HI:`SPIMSC_C0_PSC_LO]) - 8'h01;

  // apb decode, zero wait state
  // every register answers at once, so ready is a constant and the
  // access phase always lasts a single cycle
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit = (paddr == `SPIMSC_CTL0_ADDR) | (paddr == `SPIMSC_CTL1_ADDR) |
             (paddr == `SPIMSC_STAT_ADDR) | (paddr == `SPIMSC_DATA_ADDR) |
             (paddr == `SPIMSC_QCTL_ADDR);
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  wire data_wr = wr & (paddr == `SPIMSC_DATA_ADDR);
  wire data_rd = rd & (paddr == `SPIMSC_DATA_ADDR);

  // status word: busy, cfg fault, transmit empty, receive not empty
  wire [7:0] status_byte = {(st_ff != ST_IDLE), 1'b0, cfg_ff, 3'h0, tbe_ff, rne_ff};

  // read mux, registered through prdata on the setup cycle
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      case (paddr)
        `SPIMSC_CTL0_ADDR: prdata <= {16'h0000, ctl0_ff};
        `SPIMSC_CTL1_ADDR: prdata <= {24'h000000, ctl1_ff};
        `SPIMSC_STAT_ADDR: prdata <= {24'h000000, status_byte};
        `SPIMSC_DATA_ADDR: prdata <= {16'h0000, rxbuf_ff};
        `SPIMSC_QCTL_ADDR: prdata <= {29'h00000000, qctl_ff};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // internal clock divider for master mode
  // the divider is held at zero while idle, so the first half period of
  // every frame has its full length
  wire tick = (div_ff == half);
  wire s_rise = sck_s2_ff & ~sck_prev_ff;
  wire s_fall = ~sck_s2_ff & sck_prev_ff;
  wire s_edge = (s_rise | s_fall) & ~sel_lvl;
  wire busy = (st_ff != ST_IDLE);
  wire step = mst ? (busy & tick) : (busy & s_edge);
  // odd edge count within a frame is a shift when phase 0, sample when 1
  wire is_sample = edge_ff[0] ^ ~pha;
  wire frame_end = step & (edge_ff == last_edge);
  // master restarts only with data or in receive-only modes outside quad mode
  wire can_start_m = en & mst & (~tbe_ff | (rx_only_m & ~quad));
  wire start = mst ? can_start_m : (en & ~sel_lvl & ~tbe_ff);
  reg rx_bit;
  wire [15:0] rx_in = quad ? {12'h000, pins_s[3:0]} : {15'h0000, rx_bit};

  // receive bit routing per mode
  always @* begin
    rx_bit = 1'b0;
    if (mst) begin
      rx_bit = bidirectional_enable ? pins_s[0] : pins_s[1];
    end else begin
      rx_bit = bidirectional_enable ? pins_s[1] : pins_s[0];
    end
  end

  // receive word assembly at frame end
  // phase 0: the final edge is a shift edge and already shifted the last sample in,
  // so the shifter holds the whole word
  // phase 1: the final edge is a sample edge, so the last bit still sits
  // in the sample register and is merged here
  // the first edge of a frame never shifts, so no stale bit enters
  reg [15:0] nxt_rxbuf;
  reg [15:0] rx_merged;
  always @* begin
    rx_merged = 16'h0000;
    nxt_rxbuf = 16'h0000;
    // msb-first fill enters at bit 0, lsb-first fill at bit 15
    if (quad) begin
      rx_merged = {sh_ff[11:0], smp_ff[3:0]};
    end else if (lsbf) begin
      rx_merged = {smp_ff[0], sh_ff[15:1]};
    end else begin
      rx_merged = {sh_ff[14:0], smp_ff[0]};
    end
    if (pha) begin
      // eight-bit frames sit in the low byte of the buffer
      if (quad) begin
        nxt_rxbuf = {8'h00, rx_merged[7:0]};
      end else if (lsbf) begin
        nxt_rxbuf = f16 ? rx_merged : {8'h00, rx_merged[15:8]};
      end else begin
        nxt_rxbuf = f16 ? rx_merged : {8'h00, rx_merged[7:0]};
      end
    end else begin
      if (quad) begin
        nxt_rxbuf = {8'h00, sh_ff[7:0]};
      end else if (lsbf) begin
        nxt_rxbuf = f16 ? sh_ff : {8'h00, sh_ff[15:8]};
      end else begin
        nxt_rxbuf = f16 ? sh_ff : {8'h00, sh_ff[7:0]};
      end
    end
  end

  // frame shifter and flags
  always @(posedge clk) begin
    if (rst) begin
      ctl0_ff <= `SPIMSC_CTL0_RST;
      ctl1_ff <= `SPIMSC_CTL1_RST;
      qctl_ff <= `SPIMSC_QCTL_RST;
      txbuf_ff <= 16'h0000;
      rxbuf_ff <= 16'h0000;
      tbe_ff <= 1'b1;
      rne_ff <= 1'b0;
      cfg_ff <= 1'b0;
      st_ff <= ST_IDLE;
      sh_ff <= 16'h0000;
      edge_ff <= 5'd0;
      div_ff <= 8'h00;
      sck_ff <= 1'b0;
      first_ff <= 1'b0;
      smp_ff <= 5'd0;
    end else begin
      div_ff <= (tick | ~busy) ? 8'h00 : div_ff + 8'h01;
      // register writes; the fault below may still override the master bit
      if (wr & (paddr == `SPIMSC_CTL0_ADDR)) ctl0_ff <= pwdata[15:0];
      if (wr & (paddr == `SPIMSC_CTL1_ADDR)) ctl1_ff <= pwdata[7:0];
      if (wr & (paddr == `SPIMSC_QCTL_ADDR)) qctl_ff <= pwdata[2:0];
      // multi-master fault drops to slave, set wins over clear
      // quad mode drives its select, so the pin is never an input there
      if (en & mst & ~quad & ~(~swen & seldrv) & ~sel_lvl) begin
        ctl0_ff[`SPIMSC_C0_MASTER] <= 1'b0;
        cfg_ff <= 1'b1;
      end else if (wr & (paddr == `SPIMSC_STAT_ADDR) & ~pwdata[`SPIMSC_ST_CFG]) begin
        cfg_ff <= 1'b0;
      end
      // buffer write from the bus
      if (data_wr) begin
        txbuf_ff <= pwdata[15:0];
        tbe_ff <= 1'b0;
      end
      // data read clears receive flag; new frame end wins
      if (data_rd) rne_ff <= 1'b0;
      if (~mst & ~busy) sck_ff <= pol;
      // state machine
      case (st_ff)
        ST_IDLE: begin
          sck_ff <= pol;
          edge_ff <= 5'd0;
          if (start & ~data_wr) begin
            sh_ff <= lsbf ? txbuf_ff : (f16 ? txbuf_ff : {txbuf_ff[7:0], 8'h00});
            first_ff <= 1'b1;
            st_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (step) begin
            edge_ff <= edge_ff + 5'd1;
            if (mst) sck_ff <= ~sck_ff;
            // edge zero never shifts: its bit was put on the line at load
            if (is_sample) begin
              smp_ff <= rx_in[4:0];
            end else if (edge_ff != 5'd0) begin
              // shift out and take the held sample
              if (quad) sh_ff <= {sh_ff[11:0], smp_ff[3:0]};
              else if (lsbf) sh_ff <= {smp_ff[0], sh_ff[15:1]};
              else sh_ff <= {sh_ff[14:0], smp_ff[0]};
              // empty flag after first bit left
              // a word written in this same cycle keeps the buffer full
              if (first_ff) begin
                first_ff <= 1'b0;
                if (~data_wr) tbe_ff <= 1'b1;
              end
            end
            if (frame_end) st_ff <= ST_LAST;
          end
          if (~mst & sel_lvl) st_ff <= ST_IDLE;
          if (~en) st_ff <= ST_IDLE;
        end
        ST_LAST: begin
          // final sample merged, move to receive buffer
          rxbuf_ff <= nxt_rxbuf;
          rne_ff <= 1'b1;
          if (first_ff & ~data_wr) tbe_ff <= 1'b1;
          first_ff <= 1'b0;
          st_ff <= ST_IDLE;
        end
        default: st_ff <= ST_IDLE;
      endcase
    end
  end

  // pin use per mode, single-wire operation
  //   master duplex:        line 0 out, line 1 in
  //   master receive-only:  line 0 released, line 1 in
  //   master bidir out:     line 0 out, line 1 unused
  //   master bidir in:      line 0 in, line 1 unused
  //   slave duplex:         line 0 in, line 1 out while selected
  //   slave receive-only:   line 0 in, line 1 released
  //   slave bidir out:      line 1 out while selected, line 0 unused
  //   slave bidir in:       line 1 in, line 0 unused
  // quad operation: all four lines out for a write, all in for a read
  // lines 2 and 3 outside quad mode only ever drive a constant high
  // a slave releases its output line as soon as it is deselected, so
  // several slaves can share the line
  // the clock pin of a slave is never driven, whatever the mode bits say,
  // so a wrong setting cannot fight the external master

  // outgoing bit from the shifter
  wire tx_bit = lsbf ? sh_ff[0] : sh_ff[15];
  wire tx_ok = ~(mst ? rx_only_m : (ro | (bidirectional_enable & ~bdoe)));
  wire act = en & busy;

  // serial clock pin direction and idle level
  assign sck_o = mst ? sck_ff : pol;
  assign sck_oe = en & mst;
  assign sel_n_o = ~(act & mst);
  // quad mode drives its select whenever the core is enabled
  assign sel_n_oe = en & mst & ((~swen & seldrv) | quad);
  // data line drive per mode
  // lines 0 and 1 carry the single-wire bit, lines 2 and 3 idle high;
  // in quad mode every line carries one bit of the top nibble
  wire [3:0] single_o = {2'b11, tx_bit, tx_bit};
  wire [3:0] single_oe = {qctl_ff[`SPIMSC_Q_X23], qctl_ff[`SPIMSC_Q_X23],
                          en & ~mst & tx_ok & ~sel_lvl, en & mst & tx_ok};
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_line
      // quad read turns every line around to input
      assign dl_o[g] = quad ? sh_ff[12 + g] : single_o[g];
      assign dl_oe[g] = quad ? (en & ~qrd) : single_oe[g];
    end
  endgenerate

endmodule

/* File: test/spimsc_flash_model.sv */
// behavioural serial slave on the pin side, clock mode zero, msb first
`timescale 1ns/10ps
module spimsc_flash_model (
  // serial pins
  input wire sck,
  input wire sel_n,
  input wire mosi,
  output reg miso,
  // word to answer with and word last heard
  input wire [7:0] tx_word,
  output reg [7:0] rx_word
);
  reg [7:0] sh;
  reg [2:0] cnt;
  initial begin
    miso = 1'b0;
    rx_word = 8'h00;
    cnt = 3'h0;
  end
  // first bit must sit on the line before the first rising edge
  always @(negedge sel_n) begin
    sh = tx_word;
    miso = sh[7];
    cnt = 3'h0;
  end
  always @(posedge sck) if (!sel_n) begin
    rx_word = {rx_word[6:0], mosi};
    cnt = cnt + 3'h1;
  end
  // reload after every eighth bit, so a long frame repeats the word
  always @(negedge sck) if (!sel_n) begin
    sh = (cnt == 3'h0) ? tx_word : {sh[6:0], 1'b0};
    miso = sh[7];
  end
  // released line shows the inverse, so a stale bit is never taken as data
  always @(posedge sel_n) miso = ~miso;
endmodule

/* File: test/spimsc_core_chk.sv */
// port checker for the serial port core
`timescale 1ns/10ps
module spimsc_chk (
  // clock and reset
  input wire clk,
  input wire rst,
  // register bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  // pins
  input wire sck_o,
  input wire sck_oe,
  input wire sel_n_o,
  input wire sel_n_oe,
  input wire [3:0] dl_o,
  input wire [3:0] dl_oe
);
  reg [15:0] c0_ff;
  reg [2:0] q_ff;
  wire wr = psel && penable && pwrite;
  // shadow control words, updated at the same edge as the design's
  always @(posedge clk) begin
    if (rst) begin
      c0_ff <= 16'h0000;
      q_ff <= 3'h0;
    end else if (wr && paddr == 12'h000) c0_ff <= pwdata[15:0];
    else if (wr && paddr == 12'h010) q_ff <= pwdata[2:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_load; wr && paddr == 12'h00c && c0_ff[6] && sel_n_oe && sel_n_o; endsequence
  property p_ready; psel && penable |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access phase");
  property p_slv_clk; !c0_ff[2] |-> !sck_oe; endproperty
  a_slv_clk: assert property (p_slv_clk) else $error("slave drives clock");
  property p_start; s_load |-> ##[1:3] !sel_n_o; endproperty
  a_start: assert property (p_start) else $error("frame did not start");
  property p_sel_low; c0_ff[6] && sel_n_oe && sck_o != c0_ff[1] |-> !sel_n_o; endproperty
  a_sel_low: assert property (p_sel_low) else $error("clock runs unselected");
  property p_idle; c0_ff[6] && sel_n_oe && sel_n_o && $past(sel_n_o) |-> sck_o == c0_ff[1];
  endproperty
  a_idle: assert property (p_idle) else $error("clock idle level wrong");
  property p_extra; !q_ff[0] && q_ff[2] |-> dl_oe[3:2] == 2'b11 && dl_o[3:2] == 2'b11;
  endproperty
  a_extra: assert property (p_extra) else $error("extra lines not high");
  property p_quad; q_ff[0] && c0_ff[6] && c0_ff[2] |-> sck_oe && sel_n_oe; endproperty
  a_quad: assert property (p_quad) else $error("quad pins not outputs");
  property p_full; c0_ff[2] && c0_ff[15:10] == 6'h00 && !q_ff[0] && sel_n_oe && !sel_n_o
    |-> dl_oe[1:0] == 2'b01; endproperty
  a_full: assert property (p_full) else $error("duplex pin use wrong");
endmodule
bind spimsc_core spimsc_chk i_spimsc_chk (
  .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .sck_o(sck_o), .sck_oe(sck_oe),
  .sel_n_o(sel_n_o), .sel_n_oe(sel_n_oe), .dl_o(dl_o), .dl_oe(dl_oe)
);

/* File: test/test_spi_master_slave_core.sv */
// self-checking bench for the serial port core
`timescale 1ns/10ps
module test_spi_master_slave_core;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg s_sck = 1'b0;
  reg s_sel = 1'b1;
  reg s_mosi = 1'b0;
  reg [7:0] m_tx = 8'h1e;
  reg [31:0] rd;
  reg [31:0] c0;
  reg [7:0] got;
  reg err;
  integer mismatches = 0;
  integer comparisons = 0;
  integer i;
  integer k;
  wire [31:0] prdata;
  wire pready, pslverr, sck_o, sck_oe, sel_n_o, sel_n_oe, m_miso;
  wire [3:0] dl_o, dl_oe;
  wire [7:0] m_rx;
  wire sck_i = sck_oe ? sck_o : s_sck;
  wire sel_n_i = sel_n_oe ? sel_n_o : s_sel;
  // undriven extra lines toggle each cycle, so no stale level is read
  wire [3:0] dl_i = (dl_oe & dl_o) | (~dl_oe & {~clk, clk, m_miso, s_mosi});
  spimsc_core i_spimsc_core (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sck_i(sck_i), .sck_o(sck_o), .sck_oe(sck_oe),
    .sel_n_i(sel_n_i), .sel_n_o(sel_n_o), .sel_n_oe(sel_n_oe),
    .dl_i(dl_i), .dl_o(dl_o), .dl_oe(dl_oe)
  );
  spimsc_flash_model i_spimsc_flash_model (
    .sck(sck_i), .sel_n(sel_n_i), .mosi(dl_i[0]), .miso(m_miso), .tx_word(m_tx),
    .rx_word(m_rx)
  );
  always #12.5 clk = ~clk;
  task chk(input string what, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("CHECK FAILED %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task lost;
    begin
      mismatches = mismatches + 1;
      close_out;
    end
  endtask
  // one bus transfer; request held until ready is seen at an edge
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20) lost;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task wait_rne;
    integer n;
    begin
      n = 0;
      rd = 32'h0;
      while (rd[0] !== 1'b1 && n < 100) begin
        apb(1'b0, 12'h008, 32'h0);
        n = n + 1;
      end
      if (n == 100) lost;
    end
  endtask
  // one mode-zero frame as external master; link clock period is 8 cycles
  task slave_frame(input lvl, input [7:0] d);
    begin
      s_sel <= lvl;
      repeat (4) @(posedge clk);
      for (i = 7; i >= 0; i = i - 1) begin
        s_mosi <= d[i];
        repeat (4) @(posedge clk);
        s_sck <= 1'b1;
        got[i] = dl_i[1];
        repeat (4) @(posedge clk);
        s_sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      s_sel <= 1'b1;
      repeat (8) @(posedge clk);
    end
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 12'h000, 32'h0);
    chk("ctl0 reset", rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("status reset", rd, 32'h2);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped err", err, 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 12'h010, 32'h4);
    chk("extra lines", {dl_oe[3:2], dl_o[3:2]}, 32'hf);
    apb(1'b1, 12'h004, 32'h4);
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b1, 12'h000, 32'h44);
    chk("quad pins", {sck_oe, sel_n_oe}, 32'h3);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h010, 32'h0);
    // master duplex: msb first, lsb first, then a 16 bit frame
    for (k = 0; k < 3; k = k + 1) begin
      c0 = 32'h14 | (k == 1 ? 32'h80 : 32'h0) | (k == 2 ? 32'h800 : 32'h0);
      apb(1'b1, 12'h000, c0);
      apb(1'b1, 12'h000, c0 | 32'h40);
      chk("sel idle", sel_n_o, 32'h1);
      apb(1'b1, 12'h00c, 32'h5aa3);
      wait_rne;
      chk("tbe", rd[1], 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      chk("rx word", rd, k == 1 ? 32'h78 : k == 2 ? 32'h1e1e : 32'h1e);
      chk("tx word", m_rx, k == 1 ? 32'hc5 : 32'ha3);
      apb(1'b0, 12'h008, 32'h0);
      chk("rne clear", rd[0], 32'h0);
      apb(1'b1, 12'h000, c0);
      chk("sel off", sel_n_o, 32'h1);
    end
    // back to back: next word written once the first bit has left
    apb(1'b1, 12'h000, 32'h54);
    apb(1'b1, 12'h00c, 32'h00a5);
    rd = 32'h0;
    for (i = 0; i < 40 && rd[1] !== 1'b1; i = i + 1) apb(1'b0, 12'h008, 32'h0);
    chk("tbe early", rd[1], 32'h1);
    apb(1'b1, 12'h00c, 32'h00c3);
    wait_rne;
    apb(1'b0, 12'h00c, 32'h0);
    chk("b2b rx0", rd, 32'h1e);
    wait_rne;
    apb(1'b0, 12'h00c, 32'h0);
    chk("b2b rx1", rd, 32'h1e);
    chk("b2b tx1", m_rx, 32'hc3);
    apb(1'b1, 12'h000, 32'h14);
    // slave: first word loaded before the external clock starts
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h40);
    apb(1'b1, 12'h00c, 32'h96);
    chk("slave clk", sck_oe, 32'h0);
    slave_frame(1'b1, 8'h55);
    apb(1'b0, 12'h008, 32'h0);
    chk("unselected", rd[0], 32'h0);
    slave_frame(1'b0, 8'h3c);
    wait_rne;
    apb(1'b0, 12'h00c, 32'h0);
    chk("slave rx", rd, 32'h3c);
    chk("slave tx", got, 32'h96);
    // master with software select low must fall back and flag a fault
    apb(1'b1, 12'h000, 32'h204);
    apb(1'b1, 12'h000, 32'h244);
    apb(1'b0, 12'h008, 32'h0);
    chk("fault flag", rd[5], 32'h1);
    chk("fault clk", sck_oe, 32'h0);
    close_out;
  end
endmodule
